// ---- core/chs_defs.vh ----
// Purpose: constants of the card host status and interrupt block
// Assumes: 32-bit AXI4-Lite register window, byte addresses below
// Notes:   definitions only
`ifndef CHS_DEFS_VH
`define CHS_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CHS_OFF_STATUS 8'h00
`define CHS_OFF_IEN_SET 8'h04
`define CHS_OFF_IEN_CLR 8'h08
`define CHS_OFF_IEN_VIEW 8'h0C
`define CHS_OFF_COMMAND 8'h10
`define CHS_OFF_MODE 8'h14
`define CHS_OFF_DTIMEOUT 8'h18
`define CHS_OFF_RX_DATA 8'h1C
`define CHS_OFF_TX_DATA 8'h20
`define CHS_OFF_RX_CNT 8'h24
`define CHS_OFF_RX_NCNT 8'h28
`define CHS_OFF_TX_CNT 8'h2C
`define CHS_OFF_TX_NCNT 8'h30

// ----------------------------------------------------------------
// status bit positions (mask register shares the layout)
// ----------------------------------------------------------------
`define CHS_B_CMD_DONE 0
`define CHS_B_RX_RDY 1
`define CHS_B_TX_TAKEN 2
`define CHS_B_BLK_DONE 3
`define CHS_B_XFER_ACT 4
`define CHS_B_CARD_FREE 5
`define CHS_B_RX_CDONE 6
`define CHS_B_TX_CDONE 7
`define CHS_B_RX_ZERO 14
`define CHS_B_TX_ZERO 15
`define CHS_B_R_INDEX 16
`define CHS_B_R_DIR 17
`define CHS_B_R_CRC 18
`define CHS_B_R_END 19
`define CHS_B_R_TOUT 20
`define CHS_B_D_CRC 21
`define CHS_B_D_TOUT 22
`define CHS_B_OVERRUN 30
`define CHS_B_UNDERRUN 31
`define CHS_FLAG_MASK 32'hC07F_C0FF

// ----------------------------------------------------------------
// command, mode and time-out fields
// ----------------------------------------------------------------
`define CHS_CMD_RSP_HI 7
`define CHS_CMD_RSP_LO 6
`define CHS_CMD_LAT 12
`define CHS_CMD_TR_HI 17
`define CHS_CMD_TR_LO 16
`define CHS_TR_START 2'b01
`define CHS_MODE_DMA 0
`define CHS_DTO_CYC_HI 3
`define CHS_DTO_SCL_HI 6
`define CHS_DTO_SCL_LO 4

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define CHS_RST_WORD 32'h0000_0000
`define CHS_RST_CMD 32'h0000_0000
`define CHS_LAT_SHORT 7'h05
`define CHS_LAT_LONG 7'h40
`define CHS_RESP_OKAY 2'b00
`define CHS_RESP_SLVERR 2'b10

`endif

// ---- core/chs_status_irq.v ----
// Purpose: status flags, interrupt mask and register port of a
//          memory-card host controller
// Assumes: sequencer event inputs are on aclk, one-cycle pulses
// Notes:   dat0_in is a pin and is resynchronised here
//
// Contract
// - receive-ready sets when a word arrives, clears on receive-data read
// - transmit-taken stays low until the written word enters the shifter
// - block-ended sets after a write block incl CRC status; status read clears
// - DMA mode sets block-ended only on the final block, else every block
// - transfer-active follows the transfer including its CRC16 phase
// - card-free clears at response end, sets when DAT0 busy releases
// - receive-count-done sets when the receive counter reaches zero
// - transmit-count-done sets when the transmit counter reaches zero
// - receive-both-zero is high exactly when both receive counts are zero
// - transmit-both-zero is high exactly when both transmit counts are zero
// - response index mismatch sets its error; command write clears
// - missing direction bit in a response sets the direction error
// - response CRC7 failure sets its error; command write clears
// - missing response end bit sets its error; command write clears
// - no response within chosen latency sets time-out; command write clears
// - data CRC16 failure sets its error; status read clears
// - data time-out from cycles and scale sets its error; status read clears
// - lost received byte sets overrun; new transfer command clears
// - byte sent without written data sets underrun; new transfer clears
// - enable-set writes of 1 enable, enable-clear writes of 1 disable
// - mask view reads 1 for each enabled interrupt, status layout
// - command-done low during a command, set when sent, command write clears
// - latency select 0 gives 5 cycles, 1 gives 64 cycles
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "chs_defs.vh"

module chs_status_irq (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire cmd_sent,
    input wire resp_start,
    input wire resp_end,
    input wire resp_index_bad,
    input wire resp_dir_bad,
    input wire resp_crc_bad,
    input wire resp_endbit_bad,
    input wire rx_word_in,
    input wire [31:0] rx_word_data,
    input wire tx_word_load,
    input wire crc_status_sent,
    input wire xfer_active,
    input wire data_crc_bad,
    input wire data_wait,
    input wire rx_dma_beat,
    input wire tx_dma_beat,
    input wire dat0_in,
    output reg cmd_issue,
    output reg [31:0] cmd_word,
    output reg [31:0] tx_word,
    output reg dma_mode_sel,
    output reg irq
);

// ----------------------------------------------------------------
// declarations
// ----------------------------------------------------------------
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
reg [31:0] irq_mask;
reg [31:0] status;
reg [31:0] rx_word;
reg [3:0] data_timeout_cycles;
reg [2:0] data_timeout_scale;
reg [23:0] dto_count;
reg [23:0] dto_scale;
reg [6:0] lat_count;
reg resp_waiting;
reg cmd_done_flag, rx_word_ready, tx_word_taken, block_done_flag;
reg xfer_active_flag, card_free_flag;
reg resp_index_err, resp_dir_err, resp_crc_err, resp_endbit_err;
reg resp_timeout_err, data_crc_err, data_timeout_err;
reg rx_overrun_err, tx_underrun_err;
reg dat0_s1, dat0_s2, dat0_s3, dat0_level, dat0_prev;
reg [15:0] cnt [0:1];
reg [15:0] ncnt [0:1];
reg [1:0] cnt_done;
wire [1:0] both_zero;
wire [1:0] beat;
wire [31:0] wmask;
wire wr_fire, rd_fire, wr_hit;
wire wr_cmd_ok, new_xfer, rd_status, rd_rxdata, wr_tx;
wire [6:0] lat_limit;
wire [6:0] lat_next;
wire [23:0] dto_target;

// ----------------------------------------------------------------
// write channel: address and data taken in either order
// ----------------------------------------------------------------
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign wr_fire = aw_held && w_held && !s_axi_bvalid;
assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                {8{w_strb[1]}}, {8{w_strb[0]}}};
assign wr_hit = (aw_addr[1:0] == 2'b00) && (aw_addr <= `CHS_OFF_TX_NCNT)
                && (aw_addr != `CHS_OFF_STATUS)
                && (aw_addr != `CHS_OFF_IEN_VIEW)
                && (aw_addr != `CHS_OFF_RX_DATA);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= `CHS_RST_WORD;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `CHS_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CHS_RESP_OKAY : `CHS_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end
// command writes are ignored while a command is still running
assign wr_cmd_ok = wr_fire && (aw_addr == `CHS_OFF_COMMAND)
                   && cmd_done_flag;
assign new_xfer = wr_cmd_ok &&
    (w_data[`CHS_CMD_TR_HI:`CHS_CMD_TR_LO] == `CHS_TR_START);
assign wr_tx = wr_fire && (aw_addr == `CHS_OFF_TX_DATA);

// ----------------------------------------------------------------
// read channel: one read at a time, answer one cycle after accept
// ----------------------------------------------------------------
assign s_axi_arready = !s_axi_rvalid;
assign rd_fire = s_axi_arvalid && s_axi_arready;
assign rd_status = rd_fire && (s_axi_araddr == `CHS_OFF_STATUS);
assign rd_rxdata = rd_fire && (s_axi_araddr == `CHS_OFF_RX_DATA);

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= `CHS_RST_WORD;
        s_axi_rresp <= `CHS_RESP_OKAY;
    end else if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CHS_RESP_OKAY;
        case (s_axi_araddr)
            `CHS_OFF_STATUS: s_axi_rdata <= status;
            `CHS_OFF_IEN_VIEW: s_axi_rdata <= irq_mask;
            `CHS_OFF_MODE: s_axi_rdata <= {31'h0, dma_mode_sel};
            `CHS_OFF_DTIMEOUT: s_axi_rdata <= {25'h0, data_timeout_scale,
                                               data_timeout_cycles};
            `CHS_OFF_RX_DATA: s_axi_rdata <= rx_word;
            `CHS_OFF_RX_CNT: s_axi_rdata <= {16'h0, cnt[0]};
            `CHS_OFF_RX_NCNT: s_axi_rdata <= {16'h0, ncnt[0]};
            `CHS_OFF_TX_CNT: s_axi_rdata <= {16'h0, cnt[1]};
            `CHS_OFF_TX_NCNT: s_axi_rdata <= {16'h0, ncnt[1]};
            default: begin
                s_axi_rdata <= `CHS_RST_WORD;
                s_axi_rresp <= `CHS_RESP_SLVERR;
            end
        endcase
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// control registers and interrupt mask
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        irq_mask <= `CHS_RST_WORD;
        cmd_word <= `CHS_RST_CMD;
        tx_word <= `CHS_RST_WORD;
        dma_mode_sel <= 1'b0;
        data_timeout_cycles <= 4'h0;
        data_timeout_scale <= 3'h0;
        cmd_issue <= 1'b0;
        irq <= 1'b0;
    end else begin
        cmd_issue <= wr_cmd_ok;
        if (wr_fire && aw_addr == `CHS_OFF_IEN_SET)
            irq_mask <= irq_mask | (w_data & wmask & `CHS_FLAG_MASK);
        else if (wr_fire && aw_addr == `CHS_OFF_IEN_CLR)
            irq_mask <= irq_mask & ~(w_data & wmask);
        if (wr_cmd_ok)
            cmd_word <= (cmd_word & ~wmask) | (w_data & wmask);
        if (wr_tx)
            tx_word <= (tx_word & ~wmask) | (w_data & wmask);
        if (wr_fire && aw_addr == `CHS_OFF_MODE && w_strb[0])
            dma_mode_sel <= w_data[`CHS_MODE_DMA];
        if (wr_fire && aw_addr == `CHS_OFF_DTIMEOUT && w_strb[0]) begin
            data_timeout_cycles <= w_data[`CHS_DTO_CYC_HI:0];
            data_timeout_scale <=
                w_data[`CHS_DTO_SCL_HI:`CHS_DTO_SCL_LO];
        end
        irq <= |(status & irq_mask);
    end
end

// ----------------------------------------------------------------
// dat0 pin: three stages, a change counts when stages 2 and 3 agree
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        dat0_s1 <= 1'b1;
        dat0_s2 <= 1'b1;
        dat0_s3 <= 1'b1;
        dat0_level <= 1'b1;
        dat0_prev <= 1'b1;
    end else begin
        dat0_s1 <= dat0_in;
        dat0_s2 <= dat0_s1;
        dat0_s3 <= dat0_s2;
        if (dat0_s2 == dat0_s3)
            dat0_level <= dat0_s3;
        dat0_prev <= dat0_level;
    end
end

// ----------------------------------------------------------------
// transfer counters, receive at index 0, transmit at index 1
// ----------------------------------------------------------------
assign beat = {tx_dma_beat, rx_dma_beat};

genvar i;
generate
    for (i = 0; i < 2; i = i + 1) begin : g_chan
        wire wr_cnt;
        wire wr_ncnt;
        assign wr_cnt = wr_fire && (aw_addr ==
            ((i == 0) ? `CHS_OFF_RX_CNT : `CHS_OFF_TX_CNT));
        assign wr_ncnt = wr_fire && (aw_addr ==
            ((i == 0) ? `CHS_OFF_RX_NCNT : `CHS_OFF_TX_NCNT));
        assign both_zero[i] = (cnt[i] == 16'h0000) &&
                              (ncnt[i] == 16'h0000);
        always @(posedge aclk) begin
            if (!aresetn) begin
                cnt[i] <= 16'h0000;
                ncnt[i] <= 16'h0000;
                cnt_done[i] <= 1'b0;
            end else begin
                if (wr_cnt)
                    cnt[i] <= (cnt[i] & ~wmask[15:0]) |
                              (w_data[15:0] & wmask[15:0]);
                else if (beat[i] && cnt[i] == 16'h0001)
                    cnt[i] <= ncnt[i];
                else if (beat[i] && cnt[i] != 16'h0000)
                    cnt[i] <= cnt[i] - 16'h0001;
                if (wr_ncnt)
                    ncnt[i] <= (ncnt[i] & ~wmask[15:0]) |
                               (w_data[15:0] & wmask[15:0]);
                else if (beat[i] && cnt[i] == 16'h0001 && !wr_cnt)
                    ncnt[i] <= 16'h0000;
                // a counter reaching zero beats a same-cycle ncnt write; a same-cycle cnt write wins
                if (beat[i] && cnt[i] == 16'h0001 && !wr_cnt)
                    cnt_done[i] <= 1'b1;
                else if (wr_cnt || wr_ncnt)
                    cnt_done[i] <= 1'b0;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// response latency and data time-out counters
// ----------------------------------------------------------------
assign lat_limit = cmd_word[`CHS_CMD_LAT] ?
                   `CHS_LAT_LONG : `CHS_LAT_SHORT;
assign lat_next = lat_count + 7'h01;

always @* begin
    case (data_timeout_scale)
        3'd0: dto_scale = 24'h00_0001;
        3'd1: dto_scale = 24'h00_0010;
        3'd2: dto_scale = 24'h00_0080;
        3'd3: dto_scale = 24'h00_0100;
        3'd4: dto_scale = 24'h00_0400;
        3'd5: dto_scale = 24'h00_1000;
        3'd6: dto_scale = 24'h01_0000;
        default: dto_scale = 24'h10_0000;
    endcase
end
assign dto_target = dto_scale * {20'h0_0000, data_timeout_cycles};

always @(posedge aclk) begin
    if (!aresetn) begin
        resp_waiting <= 1'b0;
        lat_count <= 7'h00;
        dto_count <= 24'h00_0000;
    end else begin
        if (cmd_sent &&
            cmd_word[`CHS_CMD_RSP_HI:`CHS_CMD_RSP_LO] != 2'b00) begin
            resp_waiting <= 1'b1;
            lat_count <= 7'h00;
        end else if (resp_start || (resp_waiting && lat_next >= lat_limit))
        begin
            resp_waiting <= 1'b0;
        end else if (resp_waiting) begin
            lat_count <= lat_next;
        end
        // saturating, so a stalled wait cannot wrap round to zero
        if (!data_wait)
            dto_count <= 24'h00_0000;
        else if (dto_count < dto_target)
            dto_count <= dto_count + 24'h00_0001;
    end
end

// ----------------------------------------------------------------
// status flags: a set in the clearing cycle always wins
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        cmd_done_flag <= 1'b1;
        rx_word_ready <= 1'b0;
        rx_word <= `CHS_RST_WORD;
        tx_word_taken <= 1'b1;
        block_done_flag <= 1'b0;
        xfer_active_flag <= 1'b0;
        card_free_flag <= 1'b1;
        resp_index_err <= 1'b0;
        resp_dir_err <= 1'b0;
        resp_crc_err <= 1'b0;
        resp_endbit_err <= 1'b0;
        resp_timeout_err <= 1'b0;
        data_crc_err <= 1'b0;
        data_timeout_err <= 1'b0;
        rx_overrun_err <= 1'b0;
        tx_underrun_err <= 1'b0;
    end else begin
        if (cmd_sent)
            cmd_done_flag <= 1'b1;
        else if (wr_cmd_ok)
            cmd_done_flag <= 1'b0;
        if (rx_word_in) begin
            rx_word_ready <= 1'b1;
            rx_word <= rx_word_data;
        end else if (rd_rxdata) begin
            rx_word_ready <= 1'b0;
        end
        if (tx_word_load)
            tx_word_taken <= 1'b1;
        else if (wr_tx)
            tx_word_taken <= 1'b0;
        if (crc_status_sent && (!dma_mode_sel || both_zero[1]))
            block_done_flag <= 1'b1;
        else if (rd_status)
            block_done_flag <= 1'b0;
        xfer_active_flag <= xfer_active;
        // busy release seen on dat0, driven low by the card
        if (dat0_level && !dat0_prev)
            card_free_flag <= 1'b1;
        else if (resp_end)
            card_free_flag <= 1'b0;
        if (resp_index_bad)
            resp_index_err <= 1'b1;
        else if (wr_cmd_ok)
            resp_index_err <= 1'b0;
        if (resp_dir_bad)
            resp_dir_err <= 1'b1;
        else if (wr_cmd_ok)
            resp_dir_err <= 1'b0;
        if (resp_crc_bad)
            resp_crc_err <= 1'b1;
        else if (wr_cmd_ok)
            resp_crc_err <= 1'b0;
        if (resp_endbit_bad)
            resp_endbit_err <= 1'b1;
        else if (wr_cmd_ok)
            resp_endbit_err <= 1'b0;
        if (resp_waiting && !resp_start && lat_next >= lat_limit)
            resp_timeout_err <= 1'b1;
        else if (wr_cmd_ok)
            resp_timeout_err <= 1'b0;
        if (data_crc_bad)
            data_crc_err <= 1'b1;
        else if (rd_status)
            data_crc_err <= 1'b0;
        if (data_wait && dto_count >= dto_target)
            data_timeout_err <= 1'b1;
        else if (rd_status)
            data_timeout_err <= 1'b0;
        if (rx_word_in && rx_word_ready && !rd_rxdata)
            rx_overrun_err <= 1'b1;
        else if (new_xfer)
            rx_overrun_err <= 1'b0;
        if (tx_word_load && tx_word_taken)
            tx_underrun_err <= 1'b1;
        else if (new_xfer)
            tx_underrun_err <= 1'b0;
    end
end

always @* begin
    status = 32'h0000_0000;
    status[`CHS_B_CMD_DONE] = cmd_done_flag;
    status[`CHS_B_RX_RDY] = rx_word_ready;
    status[`CHS_B_TX_TAKEN] = tx_word_taken;
    status[`CHS_B_BLK_DONE] = block_done_flag;
    status[`CHS_B_XFER_ACT] = xfer_active_flag;
    status[`CHS_B_CARD_FREE] = card_free_flag;
    status[`CHS_B_RX_CDONE] = cnt_done[0];
    status[`CHS_B_TX_CDONE] = cnt_done[1];
    status[`CHS_B_RX_ZERO] = both_zero[0];
    status[`CHS_B_TX_ZERO] = both_zero[1];
    status[`CHS_B_R_INDEX] = resp_index_err;
    status[`CHS_B_R_DIR] = resp_dir_err;
    status[`CHS_B_R_CRC] = resp_crc_err;
    status[`CHS_B_R_END] = resp_endbit_err;
    status[`CHS_B_R_TOUT] = resp_timeout_err;
    status[`CHS_B_D_CRC] = data_crc_err;
    status[`CHS_B_D_TOUT] = data_timeout_err;
    status[`CHS_B_OVERRUN] = rx_overrun_err;
    status[`CHS_B_UNDERRUN] = tx_underrun_err;
end

endmodule // chs_status_irq

// ---- test/chs_card_model.sv ----
// Purpose: card side of the busy line
// Assumes: line pulled up, so a free card reads high
// Notes:   busy_go starts one busy span of 20 cycles
`timescale 1ns/1ps
module chs_card_model (
    input wire aclk,
    input wire busy_go,
    output wire dat0
);
    reg [5:0] left = 6'h00;
    always @(posedge aclk) begin
        if (busy_go)
            left <= 6'h14;
        else if (left != 6'h00)
            left <= left - 6'h01;
    end
    assign dat0 = (left == 6'h00);
endmodule // chs_card_model

// ---- test/chs_status_irq_checker.sv ----
// Purpose: bus and pulse checks of the status block
// Assumes: one clock domain, reset low
// Notes:   attached by bind below
`timescale 1ns/1ps
`include "chs_defs.vh"
module chs_status_irq_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire cmd_issue
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_w_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write not blocked");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read not blocked");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("late read");
    property p_b_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> !s_axi_bvalid ##2 s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("late write");
    property p_cmd_pulse;
        $rose(cmd_issue) |=> !cmd_issue;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("long cmd");
    property p_err_data;
        s_axi_rvalid && s_axi_rresp == `CHS_RESP_SLVERR |-> s_axi_rdata == 0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("err data");
endmodule // chs_status_irq_checker
bind chs_status_irq chs_status_irq_checker chk_u (.*);

// ---- test/chs_status_irq_test.sv ----
// Purpose: register-level test of the status and mask block
// Assumes: AXI4-Lite master tasks, event pulses one cycle wide
// Notes:   status read clears some flags, so order matters
`timescale 1ns/1ps
`include "chs_defs.vh"
module chs_status_irq_test;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, rx_word_data = 0, rv;
    logic [12:0] ev = 0;
    logic xfer_active = 0, data_wait = 0, bg = 0;
    logic [1:0] rr;
    int bad_count = 0, cmp_count = 0;
    wire cmd_sent, resp_start, resp_end, resp_index_bad, resp_dir_bad;
    wire resp_crc_bad, resp_endbit_bad, rx_word_in, tx_word_load;
    wire crc_status_sent, data_crc_bad, rx_dma_beat, tx_dma_beat, dat0_in;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, cmd_issue, dma_mode_sel, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, cmd_word, tx_word;
    assign {tx_dma_beat, rx_dma_beat, data_crc_bad, crc_status_sent,
        tx_word_load, rx_word_in, resp_endbit_bad, resp_crc_bad,
        resp_dir_bad, resp_index_bad, resp_end, resp_start, cmd_sent} = ev;
    chs_status_irq dut_u (.*);
    chs_card_model card_u (.aclk(aclk), .busy_go(bg), .dat0(dat0_in));
    always #2 aclk = ~aclk;
    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw;
        pa = 1;
        pw = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task st(input logic [31:0] m, e);
        rd(`CHS_OFF_STATUS);
        chk(rv & m, e);
    endtask
    task pl(input int k);
        ev <= 13'h0001 << k;
        @(posedge aclk);
        ev <= 13'h0000;
        @(posedge aclk);
    endtask
    task final_report;
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #100000;
        bad_count++;
        final_report;
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        st(32'hFFFF_FFFF, 32'h0000_C025);
        rd(`CHS_OFF_IEN_VIEW);
        chk(rv, 32'h0000_0000);
        wr(`CHS_OFF_IEN_SET, 32'hFFFF_FFFF);
        rd(`CHS_OFF_IEN_VIEW);
        chk(rv, `CHS_FLAG_MASK);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`CHS_OFF_IEN_CLR, 32'h0000_00FF);
        wr(`CHS_OFF_IEN_SET, 32'h0000_0000);
        wr(`CHS_OFF_IEN_CLR, 32'h0000_0000);
        rd(`CHS_OFF_IEN_VIEW);
        chk(rv, 32'hC07F_C000);
        wr(`CHS_OFF_IEN_CLR, 32'hFFFF_FFFF);
        rd(8'h40);
        chk({30'h0, rr}, {30'h0, `CHS_RESP_SLVERR});
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`CHS_OFF_COMMAND, 32'h0001_0040);
        st(32'h0000_0001, 32'h0000_0000);
        for (int k = 3; k < 7; k++) pl(k);
        pl(0);
        repeat (6) @(posedge aclk);
        st(32'h001F_0001, 32'h001F_0001);
        wr(`CHS_OFF_COMMAND, 32'h0000_1040);
        st(32'h001F_0000, 32'h0000_0000);
        pl(0);
        repeat (30) @(posedge aclk);
        st(32'h0010_0000, 32'h0000_0000);
        repeat (40) @(posedge aclk);
        st(32'h0010_0000, 32'h0010_0000);
        rx_word_data <= 32'hA5A5_0001;
        pl(7);
        st(32'h4000_0002, 32'h0000_0002);
        rd(`CHS_OFF_RX_DATA);
        chk(rv, 32'hA5A5_0001);
        st(32'h0000_0002, 32'h0000_0000);
        pl(7);
        pl(7);
        wr(`CHS_OFF_TX_DATA, 32'h1234_5678);
        st(32'h0000_0004, 32'h0000_0000);
        pl(8);
        chk(tx_word, 32'h1234_5678);
        st(32'h8000_0004, 32'h0000_0004);
        pl(8);
        st(32'hC000_0000, 32'hC000_0000);
        wr(`CHS_OFF_COMMAND, 32'h0001_0000);
        pl(0);
        st(32'hC010_0001, 32'h0000_0001);
        pl(9);
        st(32'h0000_0008, 32'h0000_0008);
        st(32'h0000_0008, 32'h0000_0000);
        wr(`CHS_OFF_MODE, 32'h0000_0001);
        chk({31'h0, dma_mode_sel}, 32'h0000_0001);
        wr(`CHS_OFF_TX_CNT, 32'h0000_0001);
        st(32'h0000_8080, 32'h0000_0000);
        pl(9);
        st(32'h0000_0008, 32'h0000_0000);
        pl(12);
        st(32'h0000_8080, 32'h0000_8080);
        pl(9);
        st(32'h0000_0008, 32'h0000_0008);
        wr(`CHS_OFF_RX_CNT, 32'h0000_0002);
        pl(11);
        st(32'h0000_4040, 32'h0000_0000);
        pl(11);
        st(32'h0000_4040, 32'h0000_4040);
        wr(`CHS_OFF_RX_NCNT, 32'h0000_0000);
        st(32'h0000_0040, 32'h0000_0000);
        xfer_active <= 1'b1;
        repeat (2) @(posedge aclk);
        st(32'h0000_0010, 32'h0000_0010);
        xfer_active <= 1'b0;
        @(posedge aclk);
        st(32'h0000_0010, 32'h0000_0000);
        pl(10);
        st(32'h0020_0000, 32'h0020_0000);
        st(32'h0020_0000, 32'h0000_0000);
        wr(`CHS_OFF_DTIMEOUT, 32'h0000_0000);
        data_wait <= 1'b1;
        repeat (3) @(posedge aclk);
        data_wait <= 1'b0;
        st(32'h0040_0000, 32'h0040_0000);
        st(32'h0040_0000, 32'h0000_0000);
        bg <= 1'b1;
        @(posedge aclk);
        bg <= 1'b0;
        pl(2);
        st(32'h0000_0020, 32'h0000_0000);
        repeat (30) @(posedge aclk);
        st(32'h0000_0020, 32'h0000_0020);
        final_report;
    end
endmodule // chs_status_irq_test
